// *** hdl/crd_consts.svh ***
// Constants for the clock ratio configuration decoder.
// Assumes the configuration word arrives with bit 0 as its most significant bit.
//
// Contract
// - Complexes zero and one take 0000 as first cluster PLL /1, 0001 as /2, 0100 as second /1.
// - Complexes two and three take 0000 as first /1, 0100 as second /1, 0101 as second /2.
// - Each complex decodes its own select field by the table of its pair.
// - Memory PLL uses the system reference clock when asynchronous, the platform when synchronous.
// - Asynchronous ratio codes in bits 10 to 14 give 5 to 20 to one; the rest are reserved.
// - In synchronous mode only code 0_0001 (one to one) is valid.
// - The block keeps a cutoff per asynchronous ratio and compares the reference with it.
// - In synchronous mode the memory bus clock is half the platform clock.
`ifndef CRD_CONSTS_SVH
`define CRD_CONSTS_SVH
`define CRD_AW 8
`define CRD_OFS_STAT 8'h00
`define CRD_OFS_REF 8'h04
`define CRD_OFS_LINK 8'h08
`define CRD_OFS_SRIOF 8'h0C
`define CRD_OFS_PLAT 8'h10
`define CRD_OFS_CHK 8'h14
`define CRD_SEL_BASE 64
`define CRD_SEL_W 4
`define CRD_SYNC_BIT 184
`define CRD_RATE_BIT 232
`define CRD_RSV_BIT 234
`define CRD_RAT_MSB 10
`define CRD_RAT_LSB 14
`define CRD_RNG_MSB 8
`define CRD_RNG_LSB 9
`define CRD_RNG_LO 2'h0
`define CRD_RNG_HI 2'h1
`define CRD_SEL_A1 4'h0
`define CRD_SEL_A2 4'h1
`define CRD_SEL_B1 4'h4
`define CRD_SEL_B2 4'h5
`define CRD_RAT_SYNC 5'h01
`define CRD_CUT_SYNC 16'h1770
`define CRD_PCIE_MHZ 32'h0000020F
`define CRD_PCIE_G1 32'h00000008
`define CRD_PCIE_G2 32'h00000004
`define CRD_SRIO_K 32'h0000010A
`define CRD_SRIO_SCALE 32'h00002710
`endif

// *** hdl/crd_pkg.sv ***
// Types for the clock ratio configuration decoder.
// Frequencies: reference in 0.1 MHz units, platform and RapidIO in MHz.
package crd_pkg;
  typedef logic [15:0] crd_freq_t;
  typedef logic [11:0] crd_mhz_t;
  typedef struct packed {
    logic [3:0] srio_w;
    logic gen2;
    logic [4:0] pcie_w;
  } crd_link_t;
  typedef struct packed {
    logic done;
    logic [3:0] src;
    logic [3:0] div2;
    logic [3:0] sel_bad;
    logic sync;
    logic rate;
    logic rsv;
    logic [4:0] ratio;
    logic [1:0] rng;
    logic err;
    crd_freq_t ref_f;
    crd_link_t link;
    crd_mhz_t srio_f;
    crd_mhz_t plat_f;
    logic rng_exp;
    logic rng_bad;
    logic pcie_ok;
    logic srio_ok;
    logic [31:0] rdata;
  } crd_state_t;
endpackage : crd_pkg

// *** hdl/crd_decoder.sv ***
// Clock ratio configuration decoder: turns the power-up word into clock selects.
// Assumes cfg_load_i pulses once while the word is stable; later pulses are ignored.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "crd_consts.svh"
module crd_decoder (
  input wire logic mclk_i, // 200 MHz clock
  input wire logic rst_i, // Async reset, high
  input wire logic [0:255] reset_configuration_word_i, // Latched word
  input wire logic cfg_load_i, // Capture strobe
  input wire logic [`CRD_AW-1:0] addr_i, // Register address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data
  output logic decoded_o, // Word captured
  output logic [3:0] core_src_second_o, // Complex uses second cluster
  output logic [3:0] core_div2_o, // Complex divides by two
  output logic mem_sync_o, // Memory PLL from platform
  output logic [4:0] mem_ratio_o, // Memory ratio code
  output logic mem_range_o, // Memory PLL upper range
  output logic mem_bus_half_plat_o, // Bus clock is platform /2
  output logic cfg_err_o // Reserved code seen
);
  crd_pkg::crd_state_t s_reg;
  crd_pkg::crd_state_t s_next;
  logic [3:0] dec_second;
  logic [3:0] dec_div2;
  logic [3:0] dec_bad;
  logic [4:0] w_ratio;
  logic w_sync;
  logic w_rate;
  logic w_rsv;
  logic [1:0] w_rng;

  assign w_ratio = reset_configuration_word_i[`CRD_RAT_MSB:`CRD_RAT_LSB];
  assign w_sync = reset_configuration_word_i[`CRD_SYNC_BIT];
  assign w_rate = reset_configuration_word_i[`CRD_RATE_BIT];
  assign w_rsv = reset_configuration_word_i[`CRD_RSV_BIT];
  assign w_rng = reset_configuration_word_i[`CRD_RNG_MSB:`CRD_RNG_LSB];

  // Per-complex select decode; upper pair uses its own table
  for (genvar i = 0; i < 4; i++) begin : g_cc
    logic [`CRD_SEL_W-1:0] fld;
    assign fld = reset_configuration_word_i[`CRD_SEL_BASE + i*`CRD_SEL_W +: `CRD_SEL_W];
    always_comb begin
      dec_second[i] = 1'b0;
      dec_div2[i] = 1'b0;
      dec_bad[i] = 1'b0;
      if (i < 2) begin
        case (fld)
          `CRD_SEL_A1: dec_bad[i] = 1'b0;
          `CRD_SEL_A2: dec_div2[i] = 1'b1;
          `CRD_SEL_B1: dec_second[i] = 1'b1;
          default: dec_bad[i] = 1'b1;
        endcase
      end else begin
        case (fld)
          `CRD_SEL_A1: dec_bad[i] = 1'b0;
          `CRD_SEL_B1: dec_second[i] = 1'b1;
          `CRD_SEL_B2: begin
            dec_second[i] = 1'b1;
            dec_div2[i] = 1'b1;
          end
          default: dec_bad[i] = 1'b1;
        endcase
      end
    end
  end

  // Cutoff in 0.1 MHz units; bit 16 flags a supported code
  function automatic logic [16:0] cutoff(input logic [4:0] code, input logic sync);
    logic [16:0] r;
    r = 17'h00000;
    if (sync) begin
      if (code == `CRD_RAT_SYNC) r = {1'b1, `CRD_CUT_SYNC};
    end else begin
      case (code)
        5'h05: r = {1'b1, 16'h03C7};
        5'h06: r = {1'b1, 16'h0326};
        5'h08: r = {1'b1, 16'h04B9};
        5'h09: r = {1'b1, 16'h0432};
        5'h0A: r = {1'b1, 16'h03C7};
        5'h0C: r = {1'b1, 16'h0326};
        5'h0D: r = {1'b1, 16'h02E8};
        5'h10: r = {1'b1, 16'h025C};
        5'h12: r = {1'b1, 16'h0219};
        5'h13: r = {1'b1, 16'h01FD};
        5'h14: r = {1'b1, 16'h01E4};
        default: r = 17'h00000;
      endcase
    end
    return r;
  endfunction : cutoff

  logic [16:0] cut;
  logic [31:0] pcie_need;
  logic [31:0] pcie_have;
  logic [31:0] srio_need;
  logic [31:0] srio_have;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 32'h00000000;
    // Capture only once; a second strobe cannot change clocks in flight
    if (cfg_load_i && !s_reg.done) begin
      s_next.done = 1'b1;
      s_next.src = dec_second;
      s_next.div2 = dec_div2;
      s_next.sel_bad = dec_bad;
      s_next.sync = w_sync;
      s_next.rate = w_rate;
      s_next.rsv = w_rsv;
      s_next.ratio = w_ratio;
      s_next.rng = w_rng;
    end
    if (wr_i) begin
      case (addr_i)
        `CRD_OFS_REF: s_next.ref_f = crd_pkg::crd_freq_t'(wdata_i[$bits(crd_pkg::crd_freq_t)-1:0]);
        `CRD_OFS_LINK: s_next.link = crd_pkg::crd_link_t'(wdata_i[$bits(crd_pkg::crd_link_t)-1:0]);
        `CRD_OFS_SRIOF: s_next.srio_f = wdata_i[$bits(crd_pkg::crd_mhz_t)-1:0];
        `CRD_OFS_PLAT: s_next.plat_f = crd_pkg::crd_mhz_t'(wdata_i[$bits(crd_pkg::crd_mhz_t)-1:0]);
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    cut = cutoff(s_next.ratio, s_next.sync);
    // Reference compared is ref_f in both modes, also when synchronous; plat_f feeds only the link checks
    s_next.rng_exp = cut[16] && (s_next.ref_f > cut[15:0]);
    s_next.rng_bad = s_next.done &&
      (s_next.rng != (s_next.rng_exp ? `CRD_RNG_HI : `CRD_RNG_LO));
    s_next.err = s_next.done && ((|s_next.sel_bad) || !cut[16] || s_next.rsv ||
      (s_next.sync != s_next.rate) || s_next.rng[1]);
    // Width is the widest trained port; software supplies it
    pcie_need = `CRD_PCIE_MHZ * {27'h0000000, s_next.link.pcie_w};
    pcie_have = {20'h00000, s_next.plat_f} * (s_next.link.gen2 ? `CRD_PCIE_G2 : `CRD_PCIE_G1);
    s_next.pcie_ok = pcie_have >= pcie_need;
    // 2 x 0.8512 / 64 scaled by 10000 gives 266
    srio_need = `CRD_SRIO_K * {20'h00000, s_next.srio_f} * {28'h0000000, s_next.link.srio_w};
    srio_have = `CRD_SRIO_SCALE * {20'h00000, s_next.plat_f};
    s_next.srio_ok = srio_have >= srio_need;
    if (rd_i) begin
      case (addr_i)
        `CRD_OFS_STAT: s_next.rdata = {10'h000, s_reg.done, s_reg.err, s_reg.rng,
          s_reg.sync, s_reg.ratio, s_reg.sel_bad, s_reg.div2, s_reg.src};
        `CRD_OFS_REF: s_next.rdata = {16'h0000, s_reg.ref_f};
        `CRD_OFS_LINK: s_next.rdata = {22'h000000, s_reg.link};
        `CRD_OFS_SRIOF: s_next.rdata = {20'h00000, s_reg.srio_f};
        `CRD_OFS_PLAT: s_next.rdata = {20'h00000, s_reg.plat_f};
        `CRD_OFS_CHK: s_next.rdata = {28'h0000000, s_reg.srio_ok, s_reg.pcie_ok,
          s_reg.rng_bad, s_reg.rng_exp};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign decoded_o = s_reg.done;
  assign core_src_second_o = s_reg.src;
  assign core_div2_o = s_reg.div2;
  assign mem_sync_o = s_reg.sync;
  assign mem_ratio_o = s_reg.ratio;
  assign mem_range_o = s_reg.rng_exp;
  assign mem_bus_half_plat_o = s_reg.sync;
  assign cfg_err_o = s_reg.err;

  property p_sel_low;
    @(posedge mclk_i) disable iff (rst_i)
    cfg_load_i && !decoded_o &&
    reset_configuration_word_i[`CRD_SEL_BASE + `CRD_SEL_W +: `CRD_SEL_W] == `CRD_SEL_A2
    |=> core_div2_o[1] && !core_src_second_o[1];
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("low pair divide code wrong");

  property p_sel_high;
    @(posedge mclk_i) disable iff (rst_i)
    cfg_load_i && !decoded_o &&
    reset_configuration_word_i[`CRD_SEL_BASE + 3*`CRD_SEL_W +: `CRD_SEL_W] == `CRD_SEL_B2
    |=> core_div2_o[3] && core_src_second_o[3];
  endproperty
  a_sel_high: assert property (p_sel_high) else $error("high pair divide code wrong");

  property p_sel_hold;
    @(posedge mclk_i) disable iff (rst_i)
    decoded_o |=> $stable(core_src_second_o) && $stable(core_div2_o);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selects changed after capture");

  property p_sync_src;
    @(posedge mclk_i) disable iff (rst_i)
    cfg_load_i && !decoded_o |=> mem_sync_o == $past(reset_configuration_word_i[`CRD_SYNC_BIT]);
  endproperty
  a_sync_src: assert property (p_sync_src) else $error("memory source not captured");

  property p_async_bad;
    @(posedge mclk_i) disable iff (rst_i)
    decoded_o && !mem_sync_o && mem_ratio_o == 5'h07 |-> cfg_err_o;
  endproperty
  a_async_bad: assert property (p_async_bad) else $error("reserved ratio accepted");

  property p_sync_bad;
    @(posedge mclk_i) disable iff (rst_i)
    decoded_o && mem_sync_o && mem_ratio_o != `CRD_RAT_SYNC |-> cfg_err_o;
  endproperty
  a_sync_bad: assert property (p_sync_bad) else $error("sync ratio not flagged");

  property p_cut_8;
    @(posedge mclk_i) disable iff (rst_i)
    decoded_o && !mem_sync_o && mem_ratio_o == 5'h08 && s_reg.ref_f == 16'h04B9
    |-> !mem_range_o;
  endproperty
  a_cut_8: assert property (p_cut_8) else $error("cutoff at 120.9 MHz wrong");

  property p_half;
    @(posedge mclk_i) disable iff (rst_i)
    cfg_load_i && !decoded_o |=>
    mem_bus_half_plat_o == $past(reset_configuration_word_i[`CRD_SYNC_BIT]);
  endproperty
  a_half: assert property (p_half) else $error("bus half-rate select wrong");

  property p_mismatch;
    @(posedge mclk_i) disable iff (rst_i)
    decoded_o && mem_sync_o != s_reg.rate ##1 1'b1 |-> cfg_err_o;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mode bits disagree unflagged");
endmodule : crd_decoder

// *** test/crd_cfg_src.sv ***
// Model of the configuration word source that feeds the decoder.
// Assumes the bench sets the fields, then pulses go_i for one cycle.
`timescale 1ns/1ps
module crd_cfg_src (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Async reset, high
  input wire logic [15:0] sel_i, // Complex i select in bits 4i+3..4i
  input wire logic sync_i, // Synchronous memory mode
  input wire logic rate_flip_i, // Break the rate bit on purpose
  input wire logic [4:0] ratio_i, // Memory ratio code
  input wire logic rng_i, // Upper range field wanted
  input wire logic go_i, // Issue one capture
  output logic [0:255] word_o, // Configuration word
  output logic load_o // Capture strobe
);
  always_comb begin
    // Undecoded bits carry a busy pattern, not zeros
    word_o = {32{8'h5A}};
    for (int i = 0; i < 4; i++) begin
      word_o[64+4*i +: 4] = sel_i[4*i +: 4];
    end
    word_o[10 +: 5] = ratio_i;
    word_o[8 +: 2] = {1'b0, rng_i};
    word_o[184] = sync_i;
    word_o[232] = sync_i ^ rate_flip_i;
    word_o[234] = 1'b0;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      load_o <= 1'b0;
    end else begin
      load_o <= go_i;
    end
  end
endmodule : crd_cfg_src

// *** test/tb_crd_decoder.sv ***
// Self-checking bench for the clock ratio configuration decoder.
// Assumes crd_cfg_src stands in for the configuration word source.
`timescale 1ns/1ps
module tb_crd_decoder;
  typedef struct packed {
    logic [15:0] sel; logic sync; logic rflip; logic [4:0] ratio; logic [15:0] ref_f;
    logic [3:0] src; logic [3:0] div2; logic rng; logic err;
  } crd_row_t;
  logic mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [0:255] word;
  logic load, decoded, sync, range, half, err, psync = 1'b0, rflip = 1'b0, prng = 1'b0;
  logic [15:0] sel = 16'h0;
  logic [4:0] pratio = 5'h00, ratio;
  logic [3:0] src, div2;
  crd_row_t rows [10];
  int mismatches = 0, checks = 0;

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  crd_cfg_src i_src (.mclk_i(mclk_i), .rst_i(rst_i), .sel_i(sel), .sync_i(psync),
    .rate_flip_i(rflip), .ratio_i(pratio), .rng_i(prng), .go_i(go), .word_o(word),
    .load_o(load));
  crd_decoder i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .reset_configuration_word_i(word),
    .cfg_load_i(load), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .decoded_o(decoded), .core_src_second_o(src), .core_div2_o(div2),
    .mem_sync_o(sync), .mem_ratio_o(ratio), .mem_range_o(range),
    .mem_bus_half_plat_o(half), .cfg_err_o(err));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : bus_rd

  task automatic capture(input crd_row_t r);
    @(posedge mclk_i);
    sel <= r.sel;
    psync <= r.sync;
    rflip <= r.rflip;
    pratio <= r.ratio;
    prng <= r.rng;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : capture

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    final_report;
  end

  initial begin
    rows[0] = '{16'h5410, '0, '0, 5'h05, 16'h03C8, 4'hC, 4'hA, '1, '0};
    rows[1] = '{16'h4004, '0, '0, 5'h08, 16'h04B9, 4'h9, 4'h0, '0, '0};
    rows[2] = '{16'h0005, '0, '0, 5'h14, 16'h01E5, 4'h0, 4'h0, '1, '1};
    rows[3] = '{16'h0100, '0, '0, 5'h14, 16'h01E4, 4'h0, 4'h0, '0, '1};
    rows[4] = '{16'h0000, '1, '0, 5'h01, 16'h1771, 4'h0, 4'h0, '1, '0};
    rows[5] = '{16'h0000, '1, '0, 5'h01, 16'h1770, 4'h0, 4'h0, '0, '0};
    rows[6] = '{16'h0000, '1, '0, 5'h05, 16'h1770, 4'h0, 4'h0, '0, '1};
    rows[7] = '{16'h0000, '0, '0, 5'h07, 16'h03C8, 4'h0, 4'h0, '0, '1};
    rows[8] = '{16'h0000, '0, '1, 5'h0A, 16'h03C7, 4'h0, 4'h0, '0, '1};
    rows[9] = '{16'h0000, '0, '0, 5'h0A, 16'h03C7, 4'h0, 4'h0, '0, '0};
    foreach (rows[i]) begin
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1;
      chk({31'h0, decoded}, 32'h0);
      chk({31'h0, err}, 32'h0);
      bus_wr(8'h04, {16'h0, rows[i].ref_f});
      capture(rows[i]);
      chk({31'h0, decoded}, 32'h1);
      chk({31'h0, err}, {31'h0, rows[i].err});
      chk({27'h0, ratio}, {27'h0, rows[i].ratio});
      chk({31'h0, sync}, {31'h0, rows[i].sync});
      chk({31'h0, half}, {31'h0, rows[i].sync});
      if (rows[i].err === 1'b0) begin
        chk({28'h0, src}, {28'h0, rows[i].src});
        chk({28'h0, div2}, {28'h0, rows[i].div2});
        chk({31'h0, range}, {31'h0, rows[i].rng});
      end
      $display("row %0d done", i);
    end
    // A second capture strobe must not disturb the decode
    capture(rows[0]);
    chk({27'h0, ratio}, 32'h0000000A);
    chk({31'h0, err}, 32'h0);
    $display("recapture test done");
    bus_wr(8'h00, 32'hFFFFFFFF);
    bus_rd(8'h00, d);
    chk(d, 32'h0020A000);
    @(posedge mclk_i);
    #1 chk(rdata_o, 32'h0);
    bus_rd(8'h04, d);
    chk(d, 32'h000003C7);
    bus_rd(8'h3C, d);
    chk(d, 32'h0);
    $display("register test done");
    bus_wr(8'h10, 32'h00000258);
    bus_wr(8'h0C, 32'h00000C35);
    bus_wr(8'h08, 32'h00000108);
    bus_rd(8'h14, d);
    chk(d & 32'h0000000C, 32'h0000000C);
    bus_wr(8'h08, 32'h00000228);
    bus_rd(8'h14, d);
    chk(d & 32'h0000000C, 32'h0);
    // Reference just above the 10:1 cutoff while the word's field still says low range
    bus_wr(8'h04, 32'h000003C8);
    bus_rd(8'h14, d);
    chk(d & 32'h00000003, 32'h00000003);
    chk({31'h0, range}, 32'h1);
    $display("link check test done");
    final_report;
  end
endmodule : tb_crd_decoder
